/* File: uctu_consts.svh */
`ifndef UCTU_CONSTS_SVH
`define UCTU_CONSTS_SVH

// Word indices; byte address is four times the index
`define UCTU_IDX_DATA0    6'h00
`define UCTU_IDX_DATA1    6'h01
`define UCTU_IDX_DATA2    6'h02
`define UCTU_IDX_CTRL     6'h03
`define UCTU_IDX_GCC0     6'h04
`define UCTU_IDX_GCC1     6'h05
`define UCTU_IDX_GCC2     6'h06
`define UCTU_IDX_INTSEL   6'h07
`define UCTU_IDX_STATUS   6'h08

// Control word fields
`define UCTU_CW_SC_MSB    7
`define UCTU_CW_SC_LSB    6
`define UCTU_CW_RW_MSB    5
`define UCTU_CW_RW_LSB    4
`define UCTU_CW_MODE_MSB  3
`define UCTU_CW_MODE_LSB  1

// Gate/clock control read-back positions
`define UCTU_GCC_GATE_BIT 8
`define UCTU_GCC_CLK_BIT  9
`define UCTU_GCC_OUT_BIT  10

// Reset values
`define UCTU_GCC_RST      7'h20
`define UCTU_INTSEL_RST   2'h0
`define UCTU_RW_RST       2'h3

// Timing: 10 MHz base derived from the 250 MHz system clock
`define UCTU_CLK_MHZ      250
`define UCTU_BASE_NS      100
`define UCTU_BASE_DIV     ((`UCTU_BASE_NS * `UCTU_CLK_MHZ) / 1000)
`define UCTU_BASE_HIGH    ((`UCTU_BASE_DIV + 1) / 2)
`define UCTU_DECADE       10
`define UCTU_DECADE_HIGH  5

`endif

/* File: uctu_pkg.sv */
package uctu_pkg;

  typedef enum logic [1:0] {
    UCTU_CSRC_INT  = 2'b00,
    UCTU_CSRC_EXT  = 2'b01,
    UCTU_CSRC_CASC = 2'b10,
    UCTU_CSRC_RSVD = 2'b11
  } uctu_csrc_t;

  typedef enum logic [1:0] {
    UCTU_GSRC_SW   = 2'b00,
    UCTU_GSRC_PREV = 2'b01,
    UCTU_GSRC_EXT  = 2'b10,
    UCTU_GSRC_RSVD = 2'b11
  } uctu_gsrc_t;

  typedef enum logic [1:0] {
    UCTU_RW_LATCH = 2'b00,
    UCTU_RW_LSB   = 2'b01,
    UCTU_RW_MSB   = 2'b10,
    UCTU_RW_BOTH  = 2'b11
  } uctu_rw_t;

  typedef enum logic [1:0] {
    UCTU_M_TERM  = 2'b00,
    UCTU_M_SHOT  = 2'b01,
    UCTU_M_RATE  = 2'b10,
    UCTU_M_SQUARE = 2'b11
  } uctu_mode_t;

  // Per-counter gate and clock control, bits 6..0
  typedef struct packed {
    logic       sw_gate;
    logic       gate_polarity_bit;
    uctu_gsrc_t gate_src;
    logic       clk_fall;
    uctu_csrc_t clk_src;
  } uctu_gcc_t;

endpackage : uctu_pkg

/* File: uctu_sync.sv */
`timescale 1ns/1ps
module uctu_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : uctu_sync

/* File: uctu_top.sv */
`timescale 1ns/1ps
`include "uctu_consts.svh"

// Behaviour
// - Three independent 16-bit down counters, each with clock, gate and output.
// - Initial counts from 2 through 65535 are accepted.
// - Every clock source counts on a software-selected rising or falling edge.
// - Internal clock is 10MHz, 1MHz, 100kHz or 10kHz, software selected.
// - Each counter may count an external clock pin instead.
// - Counter output clocks the next counter round robin: 0-1, 1-2, 2-0.
// - Low-active gate type enables counting while the gate is low.
// - High-active gate type enables counting while the gate is high.
// - A per-counter gate polarity bit in its gate/clock register picks the type.
// - An enabled counter waits idle and only changes on active clock edges.
// - A software gate lets host writes set the gate level directly.
// - Previous output may gate: 2 gates 0, 0 gates 1, 1 gates 2.
// - Each counter may take its gate from its own external gate pin.
// - A 16-bit counter wraps to zero after 65536 events; pairs chain to 32 bits.
// - Current count reads back; events are start value minus read value.
// - Only the user counter group is built; pacing counters are elsewhere.
// - One-shot mode gives one low pulse of start value clock periods after trigger.
// - Mode 3 gives a continuous square wave of clock divided by start value.
module uctu_top
  import uctu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  counter_clock_pin_i,
  input  wire logic [2:0]  counter_gate_pin_i,
  output logic      [2:0]  counter_out_o
);

  // Wishbone decode
  logic [5:0] idx;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;

  assign idx   = wb_adr_i[7:2];
  assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = acc & wb_we_i & wb_sel_i[0];
  assign rd    = acc & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  logic cw_wr;
  logic intsel_wr;
  assign cw_wr     = wr & (idx == `UCTU_IDX_CTRL);
  assign intsel_wr = wr & (idx == `UCTU_IDX_INTSEL);

  // Pin inputs, two flops each before use
  logic [2:0] ext_clk_s;
  logic [2:0] ext_gate_s;

  uctu_sync #(
    .W (6)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({counter_gate_pin_i, counter_clock_pin_i}),
    .q_o   ({ext_gate_s, ext_clk_s})
  );

  // Internal clock: 10 MHz base then three decades
  logic [4:0] pre_cnt;
  logic       base_step;
  logic [1:0] int_sel;
  logic       int_clk;
  logic [3:0] step;
  logic [3:0] lvl;

  assign base_step = (pre_cnt == 5'(`UCTU_BASE_DIV - 1));
  assign step[0]   = base_step;
  assign lvl[0]    = (pre_cnt < 5'(`UCTU_BASE_HIGH));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
    end else if (base_step) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  genvar d;
  generate
    for (d = 0; d < 3; d++) begin : g_dec
      logic [3:0] dec;
      assign step[d+1] = step[d] & (dec == 4'(`UCTU_DECADE - 1));
      assign lvl[d+1]  = (dec < 4'(`UCTU_DECADE_HIGH));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dec <= '0;
        end else if (step[d+1]) begin
          dec <= '0;
        end else if (step[d]) begin
          dec <= dec + 4'h1;
        end
      end
    end
  endgenerate

  // Internal clock select takes effect at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_sel <= `UCTU_INTSEL_RST;
      int_clk <= 1'b1;
    end else begin
      if (intsel_wr) begin
        int_sel <= wbyte[1:0];
      end
      int_clk <= lvl[int_sel];
    end
  end

  // Per-counter views gathered for bus read and cross-coupling
  logic [2:0]       outq;
  logic [2:0]       gate_en_v;
  logic [2:0]       clk_lvl_v;
  logic [2:0][7:0]  rd_byte;
  uctu_gcc_t [2:0]  gcc;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      localparam int P = (g + 2) % 3;

      uctu_mode_t  mode;
      uctu_rw_t    rwm;
      logic [15:0] init;
      logic [15:0] cnt;
      logic [15:0] latch;
      logic        latched;
      logic        wr_hi;
      logic        rd_hi;
      logic        load_pend;
      logic        armed;
      logic        trig_pend;
      logic        gate_prev;
      logic        clk_prev;
      logic        out_r;

      logic        hit_cw;
      logic        hit_latch;
      logic        data_wr;
      logic        data_rd;
      logic        gcc_wr;
      logic        clk_src_lvl;
      logic        clk_edge_lvl;
      logic        tick;
      logic        gate_lvl;
      logic        gate_en;
      logic        trig;
      logic        trig_now;
      logic [15:0] rd_src;
      logic        rd_msb;
      logic [15:0] sq_load;
      uctu_mode_t  cw_mode;
      uctu_rw_t    cw_rw;

      assign hit_cw  = cw_wr & (wbyte[`UCTU_CW_SC_MSB:`UCTU_CW_SC_LSB] == 2'(g));
      assign cw_rw   = uctu_rw_t'(wbyte[`UCTU_CW_RW_MSB:`UCTU_CW_RW_LSB]);
      assign hit_latch = hit_cw & (cw_rw == UCTU_RW_LATCH);
      // Modes 4 and 5 fall back to terminal-count behaviour
      assign cw_mode = wbyte[`UCTU_CW_MODE_MSB-1] ?
                       uctu_mode_t'({1'b1, wbyte[`UCTU_CW_MODE_LSB]}) :
                       wbyte[`UCTU_CW_MODE_MSB] ? UCTU_M_TERM :
                       uctu_mode_t'({1'b0, wbyte[`UCTU_CW_MODE_LSB]});
      assign data_wr = wr & (idx == 6'(`UCTU_IDX_DATA0 + g));
      assign data_rd = rd & (idx == 6'(`UCTU_IDX_DATA0 + g));
      assign gcc_wr  = wr & (idx == 6'(`UCTU_IDX_GCC0 + g));

      // Clock source and edge choice
      assign clk_src_lvl  = (gcc[g].clk_src == UCTU_CSRC_EXT)  ? ext_clk_s[g] :
                            (gcc[g].clk_src == UCTU_CSRC_CASC) ? outq[P] :
                            int_clk;
      assign clk_edge_lvl = clk_src_lvl ^ gcc[g].clk_fall;
      assign tick         = clk_edge_lvl & ~clk_prev;

      // Gate source and polarity
      assign gate_lvl = (gcc[g].gate_src == UCTU_GSRC_PREV) ? outq[P] :
                        (gcc[g].gate_src == UCTU_GSRC_EXT)  ? ext_gate_s[g] :
                        gcc[g].sw_gate;
      assign gate_en  = gcc[g].gate_polarity_bit ? gate_lvl : ~gate_lvl;
      assign trig_now = gate_en & ~gate_prev;
      assign trig     = trig_pend | trig_now;

      // Odd counts: high phase one tick longer than low phase
      assign sq_load = init[0] ? (out_r ? init - 16'h0001 : init + 16'h0001) : init;

      // Read path: latched value wins over the live count
      assign rd_src = latched ? latch : cnt;
      assign rd_msb = (rwm == UCTU_RW_MSB) | ((rwm == UCTU_RW_BOTH) & rd_hi);
      assign rd_byte[g] = rd_msb ? rd_src[15:8] : rd_src[7:0];

      assign outq[g]      = out_r;
      assign gate_en_v[g] = gate_en;
      assign clk_lvl_v[g] = clk_src_lvl;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          gcc[g] <= `UCTU_GCC_RST;
        end else if (gcc_wr) begin
          gcc[g] <= wbyte[6:0];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          clk_prev  <= 1'b1;
          gate_prev <= 1'b0;
        end else begin
          clk_prev  <= clk_edge_lvl;
          gate_prev <= gate_en;
        end
      end

      // Counting engine
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode      <= UCTU_M_TERM;
          rwm       <= uctu_rw_t'(`UCTU_RW_RST);
          init      <= '0;
          cnt       <= '0;
          out_r     <= 1'b0;
          load_pend <= 1'b0;
          armed     <= 1'b0;
          trig_pend <= 1'b0;
        end else if (hit_cw && !hit_latch) begin
          mode      <= cw_mode;
          rwm       <= cw_rw;
          out_r     <= (cw_mode != UCTU_M_TERM);
          load_pend <= 1'b0;
          armed     <= 1'b0;
          trig_pend <= 1'b0;
        end else begin
          if (tick) begin
            trig_pend <= 1'b0;
            unique case (mode)
              UCTU_M_TERM: begin
                if (load_pend) begin
                  cnt       <= init;
                  load_pend <= 1'b0;
                end else if (gate_en) begin
                  cnt <= cnt - 16'h0001;
                  if (cnt == 16'h0001) begin
                    out_r <= 1'b1;
                  end
                end
              end
              UCTU_M_SHOT: begin
                if (trig && (load_pend || armed)) begin
                  cnt       <= init;
                  out_r     <= 1'b0;
                  load_pend <= 1'b0;
                  armed     <= 1'b1;
                end else begin
                  cnt <= cnt - 16'h0001;
                  if (cnt == 16'h0001) begin
                    out_r <= 1'b1;
                  end
                end
              end
              UCTU_M_RATE: begin
                if (load_pend || (trig && armed)) begin
                  cnt       <= init;
                  out_r     <= 1'b1;
                  load_pend <= 1'b0;
                  armed     <= 1'b1;
                end else if (gate_en && armed) begin
                  if (cnt == 16'h0001) begin
                    cnt   <= init;
                    out_r <= 1'b1;
                  end else begin
                    cnt   <= cnt - 16'h0001;
                    out_r <= (cnt != 16'h0002);
                  end
                end
              end
              UCTU_M_SQUARE: begin
                if (load_pend || (trig && armed)) begin
                  cnt       <= init[0] ? init + 16'h0001 : init;
                  out_r     <= 1'b1;
                  load_pend <= 1'b0;
                  armed     <= 1'b1;
                end else if (gate_en && armed) begin
                  if (cnt <= 16'h0002) begin
                    out_r <= ~out_r;
                    cnt   <= sq_load;
                  end else begin
                    cnt <= cnt - 16'h0002;
                  end
                end
              end
            endcase
          end
          // Gate disable holds periodic outputs high right away
          if (!gate_en && (mode == UCTU_M_RATE || mode == UCTU_M_SQUARE)) begin
            out_r <= 1'b1;
          end
          // Edge between ticks waits for the next tick; one on a tick is used at once
          if (trig_now && !tick) begin
            trig_pend <= 1'b1;
          end
          if (data_wr) begin
            unique case (rwm)
              UCTU_RW_LSB: begin
                init      <= {8'h00, wbyte};
                load_pend <= 1'b1;
              end
              UCTU_RW_MSB: begin
                init      <= {wbyte, 8'h00};
                load_pend <= 1'b1;
              end
              UCTU_RW_BOTH: begin
                if (wr_hi) begin
                  init[15:8] <= wbyte;
                  load_pend  <= 1'b1;
                end else begin
                  init[7:0] <= wbyte;
                end
              end
              UCTU_RW_LATCH: begin
                init <= init;
              end
            endcase
            if (mode == UCTU_M_TERM) begin
              out_r <= 1'b0;
            end
          end
        end
      end

      // Byte pointers and count latch
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wr_hi   <= 1'b0;
          rd_hi   <= 1'b0;
          latched <= 1'b0;
          latch   <= '0;
        end else if (hit_cw && !hit_latch) begin
          wr_hi   <= 1'b0;
          rd_hi   <= 1'b0;
          latched <= 1'b0;
        end else begin
          if (hit_latch && !latched) begin
            latch   <= cnt;
            latched <= 1'b1;
          end
          if (data_wr && rwm == UCTU_RW_BOTH) begin
            wr_hi <= ~wr_hi;
          end
          if (data_rd) begin
            if (rwm == UCTU_RW_BOTH) begin
              rd_hi <= ~rd_hi;
            end
            if (rwm != UCTU_RW_BOTH || rd_hi) begin
              latched <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // Read multiplexer; unmapped words read zero
  logic [31:0] rd_mux;
  logic [31:0] gcc_rd [3];
  logic [31:0] status_rd;

  generate
    for (g = 0; g < 3; g++) begin : g_rd
      assign gcc_rd[g] = {21'h000000, outq[g], clk_lvl_v[g], gate_en_v[g], 1'b0, gcc[g]};
    end
  endgenerate

  assign status_rd = {23'h000000, clk_lvl_v, gate_en_v, outq};
  assign rd_mux = (idx == `UCTU_IDX_DATA0)  ? {24'h000000, rd_byte[0]} :
                  (idx == `UCTU_IDX_DATA1)  ? {24'h000000, rd_byte[1]} :
                  (idx == `UCTU_IDX_DATA2)  ? {24'h000000, rd_byte[2]} :
                  (idx == `UCTU_IDX_GCC0)   ? gcc_rd[0] :
                  (idx == `UCTU_IDX_GCC1)   ? gcc_rd[1] :
                  (idx == `UCTU_IDX_GCC2)   ? gcc_rd[2] :
                  (idx == `UCTU_IDX_INTSEL) ? {30'h00000000, int_sel} :
                  (idx == `UCTU_IDX_STATUS) ? status_rd :
                  32'h00000000;

  // Single-wait-state slave: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_out_o <= '0;
    end else begin
      counter_out_o <= outq;
    end
  end

endmodule : uctu_top

/* File: uctu_top_assertions.sv */
`timescale 1ns/1ps
module uctu_top_assertions
  import uctu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  counter_clock_pin_i,
  input wire logic [2:0]  counter_gate_pin_i,
  input wire logic [2:0]  counter_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       rd_req = req && !wb_we_i;
  wire [1:0] sc     = wb_dat_i[7:6];
  // Mode 0 control word to a real counter
  wire       cw     = req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h03
                      && sc != 2'h3 && wb_dat_i[5:4] != 2'h0 && wb_dat_i[3:1] == 3'h0;

  ack_timing_a: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (wb_ack_o == 1'b0 && counter_out_o == 3'h0 && wb_dat_o == 32'h0))
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (rd_req && wb_adr_i[7:2] > 6'h08 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  term_low_a: assert property (cw ##2 1'b1 |-> !counter_out_o[$past(sc, 2)])
    else $error("mode 0 output not low after control word");
  status_out_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h08
    |-> wb_dat_o[2:0] == counter_out_o)
    else $error("status output bits differ from outputs");
  data_hold_a: assert property (!rd_req |=> $stable(wb_dat_o))
    else $error("read data changed without read");

  cover property (cw);
  cover property ($rose(counter_out_o[2]));
  cover property ($fell(counter_out_o[0]));
  cover property ($fell(counter_out_o[1]));
endmodule : uctu_top_assertions

bind uctu_top uctu_top_assertions uctu_top_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .counter_clock_pin_i(counter_clock_pin_i),
  .counter_gate_pin_i(counter_gate_pin_i), .counter_out_o(counter_out_o));

/* File: uctu_src.sv */
`timescale 1ns/1ps
module uctu_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [7:0] n_i,
  output logic      [2:0] pin_o,
  output logic            busy_o
);
  logic [8:0] rem;
  logic [1:0] ph;
  assign busy_o = (rem != 9'h0);
  // Burst of n pulses, 8 cycles each; pins stand low between bursts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem   <= 9'h0;
      ph    <= 2'h0;
      pin_o <= 3'h0;
    end else if (go_i && !busy_o) begin
      rem <= {n_i, 1'b0};
      ph  <= 2'h0;
    end else if (busy_o) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        pin_o[sel_i] <= ~pin_o[sel_i];
        rem          <= rem - 9'h1;
      end
    end
  end
endmodule : uctu_src

/* File: test_user_counter_timer_unit.sv */
`timescale 1ns/1ps
`include "uctu_consts.svh"
module test_user_counter_timer_unit
  import uctu_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  cpin;
  logic [2:0]  gpin  = 3'h0;
  logic [2:0]  outs;
  logic        go    = 1'b0;
  logic [1:0]  psel  = 2'h0;
  logic [7:0]  pn    = 8'h00;
  logic        busy;
  int          err_count = 0;
  int          total_checks = 0;

  uctu_top uctu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .counter_clock_pin_i(cpin), .counter_gate_pin_i(gpin),
    .counter_out_o(outs));
  uctu_src uctu_src_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sel_i(psel),
    .n_i(pn), .pin_o(cpin), .busy_o(busy));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task load(input logic [1:0] n, input logic [15:0] v);
    wr({4'h0, n, 2'h0}, v[7:0]);
    wr({4'h0, n, 2'h0}, v[15:8]);
  endtask : load

  // Latch, then LSB and MSB reads
  task rdc(input logic [1:0] n, output logic [31:0] c);
    logic [31:0] r;
    wr(8'h0c, {n, 6'h00});
    wb(1'b0, {4'h0, n, 2'h0}, 8'h00, r);
    c = {24'h0, r[7:0]};
    wb(1'b0, {4'h0, n, 2'h0}, 8'h00, r);
    c[15:8] = r[7:0];
  endtask : rdc

  // Settle time covers the two sync flops and the edge tick
  task pulse(input logic [1:0] s, input logic [7:0] k);
    @(posedge clk_i);
    go   <= 1'b1;
    psel <= s;
    pn   <= k;
    @(posedge clk_i);
    go <= 1'b0;
    do @(posedge clk_i); while (busy === 1'b1);
    repeat (6) @(posedge clk_i);
  endtask : pulse

  task t_reset;
    logic [31:0] r;
    wb(1'b0, 8'h10, 8'h00, r);
    chk("gcc0 reset", r & 32'h7f, 32'h20);
    wb(1'b0, 8'h1c, 8'h00, r);
    chk("intsel reset", r, 32'h0);
    wb(1'b0, 8'h40, 8'h00, r);
    chk("unmapped read", r, 32'h0);
  endtask : t_reset

  task t_event;
    logic [31:0] c;
    wr(8'h0c, 8'h30);
    wr(8'h10, 8'h31);
    load(2'h0, 16'hffff);
    pulse(2'h0, 8'h05);
    rdc(2'h0, c);
    chk("pin gate low", c, 32'hffff);
    gpin[0] <= 1'b1;
    pulse(2'h0, 8'h04);
    rdc(2'h0, c);
    chk("pin gate high", c, 32'hfffb);
    wr(8'h10, 8'h11);
    pulse(2'h0, 8'h03);
    rdc(2'h0, c);
    chk("low type off", c, 32'hfffb);
    gpin[0] <= 1'b0;
    pulse(2'h0, 8'h02);
    rdc(2'h0, c);
    chk("low type on", c, 32'hfff9);
  endtask : t_event

  task t_term;
    wr(8'h0c, 8'h70);
    wr(8'h14, 8'h61);
    load(2'h1, 16'h0002);
    pulse(2'h1, 8'h02);
    chk("term early", outs[1], 1'b0);
    pulse(2'h1, 8'h01);
    chk("term reached", outs[1], 1'b1);
  endtask : t_term

  task t_shot;
    wr(8'h0c, 8'h32);
    wr(8'h10, 8'h21);
    load(2'h0, 16'h0003);
    wr(8'h10, 8'h61);
    pulse(2'h0, 8'h03);
    chk("shot low", outs[0], 1'b0);
    pulse(2'h0, 8'h01);
    chk("shot end", outs[0], 1'b1);
    pulse(2'h0, 8'h03);
    chk("shot single", outs[0], 1'b1);
  endtask : t_shot

  // Counter 1 terminal counts clock counter 2
  task t_casc;
    logic [31:0] c;
    wr(8'h0c, 8'hb0);
    wr(8'h18, 8'h62);
    load(2'h2, 16'hffff);
    wr(8'h0c, 8'h70);
    for (int i = 0; i < 3; i++) begin
      load(2'h1, 16'h0002);
      pulse(2'h1, 8'h03);
    end
    rdc(2'h2, c);
    chk("cascade count", c, 32'hfffd);
  endtask : t_casc

  task rise(output time t);
    while (outs[2] !== 1'b0) @(posedge clk_i);
    while (outs[2] !== 1'b1) @(posedge clk_i);
    t = $time;
  endtask : rise

  task t_square;
    time t0;
    time t1;
    wr(8'h18, 8'h60);
    wr(8'h0c, 8'hb6);
    load(2'h2, 16'h0004);
    for (int s = 0; s < 2; s++) begin
      wr(8'h1c, s[7:0]);
      rise(t0);
      rise(t0);
      rise(t1);
      chk("square period", (t1 - t0) / 4, 4 * `UCTU_BASE_DIV * (10 ** s));
    end
  endtask : t_square

  // Counter 1 in mode 2, LSB only, falling edge, gated by counter 0
  task t_rate;
    logic [31:0] r;
    wr(8'h0c, 8'h30);
    wr(8'h14, 8'h2d);
    wr(8'h0c, 8'h54);
    wr(8'h04, 8'h03);
    pulse(2'h1, 8'h02);
    chk("rate gated out", outs[1], 1'b1);
    wr(8'h0c, 8'h40);
    wb(1'b0, 8'h04, 8'h00, r);
    chk("rate gated count", r, 32'h03);
    wr(8'h0c, 8'h32);
    pulse(2'h1, 8'h02);
    chk("rate high", outs[1], 1'b1);
    @(posedge clk_i);
    go   <= 1'b1;
    psel <= 2'h1;
    pn   <= 8'h01;
    @(posedge clk_i);
    go <= 1'b0;
    while (cpin[1] !== 1'b1) @(posedge clk_i);
    // Rising pin edge has settled here, falling edge not yet
    repeat (5) @(posedge clk_i);
    chk("rising ignored", outs[1], 1'b1);
    while (busy === 1'b1) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    chk("rate low tick", outs[1], 1'b0);
    pulse(2'h1, 8'h01);
    chk("rate reload", outs[1], 1'b1);
    wb(1'b0, 8'h20, 8'h00, r);
    chk("status gates", r & 32'hfb, 32'h3b);
  endtask : t_rate

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_event;
    t_term;
    t_shot;
    t_casc;
    t_square;
    t_rate;
    print_verdict;
  end

  // Tests need about 4000 cycles
  initial begin
    #200000;
    err_count++;
    print_verdict;
  end
endmodule : test_user_counter_timer_unit
